//--- include/eba_defines.vh
// constants for the external bus arbitration and dma pin handshake block
`ifndef EBA_DEFINES_VH
`define EBA_DEFINES_VH
`define EBA_ID_W        3
`define EBA_NPROC       8
`define EBA_NDMA        4
`define EBA_HOST_SPACE  4'h0
`define EBA_ADDR_HI     31
`define EBA_ADDR_LO     28
`define EBA_ST_SLAVE    3'h0
`define EBA_ST_MASTER   3'h1
`define EBA_ST_DRAIN    3'h2
`define EBA_ST_SELFREF  3'h3
`define EBA_ST_HOST     3'h4
`define EBA_ST_YIELD    3'h5
`define EBA_SREF_CYC    4'h4
`define EBA_ZERO4       4'h0
`define EBA_ONE4        4'h1
`define EBA_ALL8        8'hff
`define EBA_ALL3        3'h7
`endif

//--- hw/eba_sync2.v
// two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module eba_sync2 #(
   parameter W    = 1,
   parameter INIT = 0
) (
   input  wire         i_clk,
   input  wire         i_reset_n,
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta;
   // first stage is read only by the second stage
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta   <= INIT[W-1:0];
         o_sync <= INIT[W-1:0];
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // eba_sync2
`default_nettype wire

//--- hw/eba_arbiter.v
// external bus arbitration, priority lines and dma/flyby pin handshake
// Function
// - answer a host bus request by asserting host grant.
// - on giving up the bus, tri-state address, data, selects, strobes, sdram controls.
// - put attached sdram into self-refresh before granting the host.
// - keep host grant while host request is held; host releases by dropping it.
// - only the bus master drives host grant; slaves only monitor it.
// - assert core priority while the core accesses external memory.
// - on slave core priority, master suspends background dma and yields bus.
// - core and dma priority lines are open-drain, pull low only.
// - assert dma priority while a high-priority dma channel accesses memory.
// - on slave dma priority, master suspends normal dma but keeps the bus.
// - four asynchronous dma requests start transfers on initialised channels.
// - ignore dma requests of uninitialised channels.
// - flyby channels produce flyby transactions between io device and memory.
// - assert flyby strobe during each flyby transaction.
// - assert io output enable only on flyby transactions.
// - on host request, finish outstanding transaction, release bus, grant host.
// - drive the bus request line chosen by identity, monitor all others.
// - back-off releases bus early only for a transaction outside host space.
`timescale 1ns/10ps
`default_nettype none
`include "eba_defines.vh"
module eba_arbiter (
   input  wire        I_CLK_SYS,
   input  wire        I_RESET_N,
   input  wire [2:0]  I_PROCESSOR_IDENTITY,
   input  wire        I_HOST_REQUEST_N,
   input  wire        I_BACK_OFF_N,
   input  wire        I_HOST_GRANT_N,
   input  wire [7:0]  I_BUS_REQUEST_LINES_N,
   input  wire        I_CORE_PRIORITY_LINE_N,
   input  wire        I_DMA_PRIORITY_LINE_N,
   input  wire [3:0]  I_DMA_REQUEST_INPUTS_N,
   input  wire        I_CORE_ACCESS,
   input  wire [3:0]  I_DMA_CHAN_INIT,
   input  wire [3:0]  I_DMA_CHAN_FLYBY,
   input  wire [3:0]  I_DMA_CHAN_HIPRI,
   input  wire        I_XFER_ACTIVE,
   input  wire        I_XFER_DONE,
   input  wire [31:0] I_XFER_ADDR,
   output reg         O_HOST_GRANT_N,
   output reg         O_HOST_GRANT_OE_N,
   output reg         O_BUS_PINS_OE_N,
   output reg         O_SDRAM_SELF_REFRESH,
   output reg  [7:0]  O_BUS_REQUEST_LINES_N,
   output reg  [7:0]  O_BUS_REQUEST_OE_N,
   output reg         O_CORE_PRIORITY_LINE_N,
   output reg         O_CORE_PRIORITY_OE_N,
   output reg         O_DMA_PRIORITY_LINE_N,
   output reg         O_DMA_PRIORITY_OE_N,
   output reg  [3:0]  O_DMA_SERVICE,
   output reg         O_DMA_SUSPEND_NORMAL,
   output reg         O_DMA_SUSPEND_ALL,
   output reg         O_FLYBY_N,
   output reg         O_IO_OUTPUT_ENABLE_N,
   output reg         O_BUS_MASTER
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronised pin inputs
   wire [7:0] br_s;
   wire [3:0] dmar_s;
   wire       hbr_s;
   wire       back_off_s;
   wire       cpa_s;
   wire       dpa_s;
   wire       hbg_s;
   // shared priority lines are sampled on our clock, never used raw
   eba_sync2 #(.W(17), .INIT(17'h1_ffff)) u_sync (
      .i_clk     (I_CLK_SYS),
      .i_reset_n (I_RESET_N),
      .i_async   ({I_BUS_REQUEST_LINES_N, I_DMA_REQUEST_INPUTS_N, I_HOST_REQUEST_N,
                   I_BACK_OFF_N, I_CORE_PRIORITY_LINE_N, I_DMA_PRIORITY_LINE_N,
                   I_HOST_GRANT_N}),
      .o_sync    ({br_s, dmar_s, hbr_s, back_off_s, cpa_s, dpa_s, hbg_s})
   );
   ////////////////////////////////////////////////////////////////////////////
   // identity, caught after reset release since it only changes under reset
   reg  [2:0] my_id;
   reg        id_taken;
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         my_id    <= 3'h0;
         id_taken <= 1'b0;
      end else if (!id_taken) begin
         my_id    <= I_PROCESSOR_IDENTITY;
         id_taken <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // our own pull reaches the sampled line up to three edges late, so a low seen
   // in that span may be our own echo; a peer pulling in that span is missed
   reg  [2:0] own_cpa_hist;
   reg  [2:0] own_dpa_hist;
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         own_cpa_hist <= `EBA_ALL3;
         own_dpa_hist <= `EBA_ALL3;
      end else begin
         own_cpa_hist <= {own_cpa_hist[1:0], O_CORE_PRIORITY_OE_N};
         own_dpa_hist <= {own_dpa_hist[1:0], O_DMA_PRIORITY_OE_N};
      end
   end
   wire own_cpa_quiet = (&own_cpa_hist) && O_CORE_PRIORITY_OE_N;
   wire own_dpa_quiet = (&own_dpa_hist) && O_DMA_PRIORITY_OE_N;
   ////////////////////////////////////////////////////////////////////////////
   // local activity and priority classes
   wire [3:0] dma_live   = ~dmar_s & I_DMA_CHAN_INIT;
   wire       want_bus   = I_CORE_ACCESS | (|dma_live);
   wire       hi_dma     = |(dma_live & I_DMA_CHAN_HIPRI);
   wire       host_space = I_XFER_ADDR[`EBA_ADDR_HI:`EBA_ADDR_LO] != `EBA_HOST_SPACE;
   wire [7:0] my_mask    = 8'h01 << my_id;
   wire [7:0] other_req  = ~br_s & ~my_mask;
   wire       lower_req  = |(other_req & (my_mask - 8'h01));
   wire       slave_cpa  = !cpa_s && !I_CORE_ACCESS && own_cpa_quiet;
   wire       slave_dpa  = !dpa_s && !hi_dma && own_dpa_quiet;
   ////////////////////////////////////////////////////////////////////////////
   // mastership state machine
   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] sref_cnt;
   always @* begin
      next_state = state;
      case (state)
         `EBA_ST_SLAVE: begin
            // lowest identity wins among requesters; none wins while host request or grant is low
            if (want_bus && !lower_req && hbg_s && hbr_s)
               next_state = `EBA_ST_MASTER;
         end
         `EBA_ST_MASTER: begin
            if (!hbr_s)
               next_state = `EBA_ST_DRAIN;
            else if ((slave_cpa || (!want_bus && |other_req)) && !I_XFER_ACTIVE)
               next_state = `EBA_ST_YIELD;
         end
         `EBA_ST_DRAIN: begin
            if (hbr_s)
               next_state = `EBA_ST_MASTER;
            else if (!I_XFER_ACTIVE || I_XFER_DONE || (!back_off_s && host_space))
               next_state = `EBA_ST_SELFREF;
         end
         `EBA_ST_SELFREF: begin
            if (sref_cnt == `EBA_SREF_CYC)
               next_state = `EBA_ST_HOST;
         end
         `EBA_ST_HOST: begin
            if (hbr_s)
               next_state = `EBA_ST_MASTER;
         end
         `EBA_ST_YIELD: next_state = `EBA_ST_SLAVE;
         default:       next_state = `EBA_ST_SLAVE;
      endcase
   end
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state    <= `EBA_ST_SLAVE;
         sref_cnt <= `EBA_ZERO4;
      end else begin
         state    <= next_state;
         if (state == `EBA_ST_SELFREF)
            sref_cnt <= sref_cnt + `EBA_ONE4;
         else
            sref_cnt <= `EBA_ZERO4;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // registered pin drive; open-drain lines only ever pull low
   wire is_master = (state == `EBA_ST_MASTER) || (state == `EBA_ST_DRAIN) ||
                    (state == `EBA_ST_SELFREF) || (state == `EBA_ST_HOST);
   wire own_bus   = (state == `EBA_ST_MASTER) || (state == `EBA_ST_DRAIN);
   wire flyby     = |(dma_live & I_DMA_CHAN_FLYBY) && own_bus && I_XFER_ACTIVE;
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_HOST_GRANT_N         <= 1'b1;
         O_HOST_GRANT_OE_N      <= 1'b1;
         O_BUS_PINS_OE_N        <= 1'b1;
         O_SDRAM_SELF_REFRESH   <= 1'b0;
         O_BUS_REQUEST_LINES_N  <= `EBA_ALL8;
         O_BUS_REQUEST_OE_N     <= `EBA_ALL8;
         O_CORE_PRIORITY_LINE_N <= 1'b0;
         O_CORE_PRIORITY_OE_N   <= 1'b1;
         O_DMA_PRIORITY_LINE_N  <= 1'b0;
         O_DMA_PRIORITY_OE_N    <= 1'b1;
         O_DMA_SERVICE          <= `EBA_ZERO4;
         O_DMA_SUSPEND_NORMAL   <= 1'b0;
         O_DMA_SUSPEND_ALL      <= 1'b0;
         O_FLYBY_N              <= 1'b1;
         O_IO_OUTPUT_ENABLE_N   <= 1'b1;
         O_BUS_MASTER           <= 1'b0;
      end else begin
         // grant stays low while the host holds its request
         O_HOST_GRANT_N         <= !(next_state == `EBA_ST_HOST);
         O_HOST_GRANT_OE_N      <= !id_taken || !(next_state == `EBA_ST_SELFREF ||
                                   next_state == `EBA_ST_HOST ||
                                   next_state == `EBA_ST_DRAIN);
         O_BUS_PINS_OE_N        <= !(next_state == `EBA_ST_MASTER ||
                                     next_state == `EBA_ST_DRAIN);
         O_SDRAM_SELF_REFRESH   <= (next_state == `EBA_ST_SELFREF) ||
                                   (next_state == `EBA_ST_HOST);
         O_BUS_REQUEST_LINES_N  <= ~my_mask;
         O_BUS_REQUEST_OE_N     <= (want_bus && id_taken) ? ~my_mask : `EBA_ALL8;
         O_CORE_PRIORITY_LINE_N <= 1'b0;
         O_CORE_PRIORITY_OE_N   <= !I_CORE_ACCESS;
         O_DMA_PRIORITY_LINE_N  <= 1'b0;
         O_DMA_PRIORITY_OE_N    <= !hi_dma;
         O_DMA_SERVICE          <= own_bus ? dma_live : `EBA_ZERO4;
         // suspension lifts as soon as the sampled line goes high again
         O_DMA_SUSPEND_NORMAL   <= is_master && slave_dpa;
         O_DMA_SUSPEND_ALL      <= is_master && slave_cpa;
         O_FLYBY_N              <= !flyby;
         O_IO_OUTPUT_ENABLE_N   <= !flyby;
         O_BUS_MASTER           <= is_master;
      end
   end
endmodule // eba_arbiter
`default_nettype wire

//--- bench/eba_assertions.sv
// pin-level assertions for the arbiter
`timescale 1ns/10ps
`default_nettype none
module eba_assertions (
   input wire logic       I_CLK_SYS, I_RESET_N, I_HOST_REQUEST_N, I_CORE_ACCESS,
   input wire logic [2:0] I_PROCESSOR_IDENTITY,
   input wire logic [3:0] I_DMA_CHAN_INIT, O_DMA_SERVICE,
   input wire logic       O_HOST_GRANT_N, O_HOST_GRANT_OE_N, O_BUS_PINS_OE_N,
   input wire logic       O_SDRAM_SELF_REFRESH, O_FLYBY_N, O_IO_OUTPUT_ENABLE_N,
   input wire logic       O_CORE_PRIORITY_LINE_N, O_CORE_PRIORITY_OE_N, O_DMA_PRIORITY_LINE_N,
   input wire logic [7:0] O_BUS_REQUEST_OE_N
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);
   sequence req_held; !I_HOST_REQUEST_N [*3]; endsequence
   sequence granted; !O_HOST_GRANT_N && !O_HOST_GRANT_OE_N; endsequence
   a_pins_off_grant: assert property (granted |-> O_BUS_PINS_OE_N)
      else $error("bus pins driven under grant");
   a_sref_first: assert property ($fell(O_HOST_GRANT_N) |-> $past(O_SDRAM_SELF_REFRESH, 4))
      else $error("grant before self refresh");
   a_grant_held: assert property (req_held ##0 granted |=> !O_HOST_GRANT_N)
      else $error("grant dropped early");
   a_grant_driven: assert property ($fell(O_HOST_GRANT_N) |-> !O_HOST_GRANT_OE_N)
      else $error("grant not driven");
   a_core_pri_pull: assert property (I_CORE_ACCESS |=> !O_CORE_PRIORITY_OE_N)
      else $error("core priority not pulled");
   a_open_drain_low: assert property (!O_CORE_PRIORITY_LINE_N && !O_DMA_PRIORITY_LINE_N)
      else $error("priority value high");
   a_own_req_line: assert property
      ((~O_BUS_REQUEST_OE_N & ~(8'h01 << I_PROCESSOR_IDENTITY)) == 8'h00)
      else $error("foreign request line driven");
   a_io_output_enable_flyby: assert property (!O_IO_OUTPUT_ENABLE_N |-> !O_FLYBY_N)
      else $error("io enable outside flyby");
   a_uninit_quiet: assert property ((O_DMA_SERVICE & ~$past(I_DMA_CHAN_INIT)) == 4'h0)
      else $error("uninitialised channel served");
endmodule // eba_assertions
bind eba_arbiter eba_assertions u_eba_assertions (.*);
`default_nettype wire

//--- bench/eba_partner.sv
// host and shared open-drain wires facing the arbiter
`timescale 1ns/10ps
`default_nettype none
module eba_partner (
   input  wire logic       i_clk,
   input  wire logic       i_want,
   input  wire logic       i_grant_n,
   input  wire logic       i_grant_oe_n,
   input  wire logic [1:0] i_peer_n,
   input  wire logic       i_cpa_oe_n,
   input  wire logic       i_dpa_oe_n,
   output var  logic       o_req_n,
   output wire logic       o_grant_w,
   output wire logic       o_cpa_w,
   output wire logic       o_dpa_w
);
   // released grant wire floats back to its pull-up
   assign o_grant_w = i_grant_oe_n ? 1'b1 : i_grant_n;
   // wired-and with the peers, pulled up when nobody pulls
   assign o_cpa_w = i_cpa_oe_n & i_peer_n[0];
   assign o_dpa_w = i_dpa_oe_n & i_peer_n[1];
   // request is a level, held until the host is done with the bus
   always @(negedge i_clk) o_req_n <= ~i_want;
endmodule // eba_partner
`default_nettype wire

//--- bench/eba_arbiter_bench.sv
// self-checking bench for the arbiter
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, a); end end
module eba_arbiter_bench;
   logic       clk = 1'b0, rst_n = 1'b0, want = 1'b0, core = 1'b0, xact = 1'b0, xdone = 1'b0;
   logic [1:0] peer_n = 2'b11;
   logic [3:0] dreq_n = 4'hf, init = 4'h3, flyby = 4'h2, hipri = 4'h1, svc;
   logic       g_n, g_oe, pins_oe, sref, cpoe, dpoe, sn, sa, fly_n, io_output_enable_n, mst;
   logic [7:0] brl, broe;
   wire        req_n, grant_w, cpa_w, dpa_w;
   int         errors = 0, cmp_count = 0;
   eba_partner u_eba_partner (.i_clk(clk), .i_want(want), .i_grant_n(g_n), .i_grant_oe_n(g_oe),
      .i_peer_n(peer_n), .i_cpa_oe_n(cpoe), .i_dpa_oe_n(dpoe), .o_req_n(req_n),
      .o_grant_w(grant_w), .o_cpa_w(cpa_w), .o_dpa_w(dpa_w));
   eba_arbiter u_eba_arbiter (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PROCESSOR_IDENTITY(3'h0),
      .I_HOST_REQUEST_N(req_n), .I_BACK_OFF_N(1'b1), .I_HOST_GRANT_N(grant_w),
      .I_BUS_REQUEST_LINES_N(broe | brl), .I_CORE_PRIORITY_LINE_N(cpa_w),
      .I_DMA_PRIORITY_LINE_N(dpa_w), .I_DMA_REQUEST_INPUTS_N(dreq_n), .I_CORE_ACCESS(core),
      .I_DMA_CHAN_INIT(init), .I_DMA_CHAN_FLYBY(flyby), .I_DMA_CHAN_HIPRI(hipri),
      .I_XFER_ACTIVE(xact), .I_XFER_DONE(xdone), .I_XFER_ADDR(32'h0000_0000),
      .O_HOST_GRANT_N(g_n), .O_HOST_GRANT_OE_N(g_oe), .O_BUS_PINS_OE_N(pins_oe),
      .O_SDRAM_SELF_REFRESH(sref), .O_BUS_REQUEST_LINES_N(brl), .O_BUS_REQUEST_OE_N(broe),
      .O_CORE_PRIORITY_LINE_N(), .O_CORE_PRIORITY_OE_N(cpoe), .O_DMA_PRIORITY_LINE_N(),
      .O_DMA_PRIORITY_OE_N(dpoe), .O_DMA_SERVICE(svc), .O_DMA_SUSPEND_NORMAL(sn),
      .O_DMA_SUSPEND_ALL(sa), .O_FLYBY_N(fly_n), .O_IO_OUTPUT_ENABLE_N(io_output_enable_n), .O_BUS_MASTER(mst));
   always #5 clk = ~clk;
   // each transaction completes one cycle after it starts
   always @(negedge clk) xdone <= xact & ~xdone;
   ////////////////////////////////////////////////////////////////////////////////
   // bounded wait, so a stuck handshake shows as a mismatch instead of a hang
   task automatic wait_for(ref logic s, input logic v);
      for (int n = 0; n < 40 && s !== v; n++) @(negedge clk);
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task t_host;
      // only the master hands the bus to the host, so win it first
      core = 1'b1;
      wait_for(mst, 1'b1);
      `CHK("master", 1'b1, mst)
      core = 1'b0;
      repeat (4) @(negedge clk);
      want = 1'b1;
      wait_for(g_n, 1'b0);
      `CHK("host grant", 1'b0, grant_w)
      `CHK("self refresh", 1'b1, sref)
      `CHK("bus pins off", 1'b1, pins_oe)
      repeat (6) @(negedge clk);
      `CHK("grant held", 1'b0, grant_w)
      want = 1'b0;
      wait_for(pins_oe, 1'b0);
      `CHK("grant gone", 1'b1, grant_w)
      `CHK("pins back", 1'b0, pins_oe)
      $display("host handover done");
   endtask
   task t_core;
      core = 1'b1;
      @(negedge clk);
      `CHK("core pull", 1'b0, cpa_w)
      core = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("core free", 1'b1, cpa_w)
      $display("core priority done");
   endtask
   task t_dma;
      dreq_n = 4'hb;
      xact = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("uninit", 4'h0, svc)
      dreq_n = 4'he;
      wait_for(dpoe, 1'b0);
      `CHK("dma pull", 1'b0, dpa_w)
      dreq_n = 4'hd;
      wait_for(fly_n, 1'b0);
      `CHK("flyby", 1'b0, fly_n)
      `CHK("io enable", 1'b0, io_output_enable_n)
      peer_n = 2'b10;
      wait_for(sa, 1'b1);
      `CHK("suspend all", 1'b1, sa)
      peer_n = 2'b01;
      wait_for(sn, 1'b1);
      `CHK("suspend normal", 1'b1, sn)
      peer_n = 2'b11;
      wait_for(sn, 1'b0);
      `CHK("resume", 1'b0, sn)
      dreq_n = 4'hf;
      xact = 1'b0;
      $display("dma and flyby done");
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_host;
      t_core;
      t_dma;
      finish_test;
   end
   initial begin
      #20000;
      errors++;
      finish_test;
   end
endmodule // eba_arbiter_bench
`default_nettype wire
